/* File: verilog/gpio_cfg.svh */
// Register map, field positions, reset values and bus codes of the port block
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

// ********************************************************
// Register indices (byte address is four times the index)
// ********************************************************
`define AP_LATCH_IDX 14'h0007
`define AP_DIR_IDX 14'h1f8d
`define CONV_CTRL_IDX 14'h1f90
`define GEN_BASE_IDX 14'h1fa0
`define GEN_SPAN 14'h0014

// ********************************************************
// Fields of a general port register group
// ********************************************************
`define FIELD_DATA 2'h0
`define FIELD_DIR 2'h1
`define FIELD_DRIVE 2'h2
`define FIELD_RMW 2'h3

// ********************************************************
// Converter control fields
// ********************************************************
`define CONV_DISABLE_BIT 7
`define CONV_CHAN_HI 3
`define CONV_CHAN_LO 0
// Analog port bit shared with the debug output
`define DEBUG_BIT 7

// ********************************************************
// Reset values
// ********************************************************
`define AP_RESET 8'h00
`define GEN_RESET 8'h00
`define DISABLE_RESET 1'b1
`define CHAN_RESET 4'h0

// ********************************************************
// Bus codes
// ********************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define WORD_ZERO 32'h0000_0000
`define LANE_ALIGN 2'h0

`endif

/* File: verilog/gpio_pkg.sv */
// Types shared by the port block files
package gpio_pkg;

  // ********************************************************
  // Address decode result
  // ********************************************************
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_AP_LATCH = 3'h1,
    SEL_AP_DIR = 3'h3,
    SEL_CONV = 3'h2,
    SEL_GEN = 3'h6
  } sel_t;

  typedef struct packed {
    sel_t sel;
    logic [2:0] port;
    logic [1:0] field;
  } dec_t;

  // ********************************************************
  // Write strobe carried to one general port
  // ********************************************************
  typedef struct packed {
    logic en;
    logic [1:0] field;
    logic [7:0] data;
  } port_wr_t;

  // ********************************************************
  // Whole state of the top module
  // ********************************************************
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_held;
    logic [15:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ap_latch;
    logic [7:0] ap_dir;
    logic analog_input_disable;
    logic [3:0] chan;
    logic [7:0] ap_out;
    logic [7:0] ap_oe;
  } top_state_t;

endpackage : gpio_pkg

/* File: verilog/general_port.sv */
// One general port with direction, output latch and drive-type selection
`timescale 1ns/10ps
`include "gpio_cfg.svh"

module general_port #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire gpio_pkg::port_wr_t wr,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pin_rd,
  output logic [WIDTH-1:0] rmw_rd,
  output logic [WIDTH-1:0] dir_rd,
  output logic [WIDTH-1:0] drive_rd
);

  typedef struct packed {
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] drive;
    logic [WIDTH-1:0] out;
    logic [WIDTH-1:0] oe;
  } port_state_t;

  port_state_t state_reg;
  port_state_t state_next;

  // ********************************************************
  // Register writes and pin drive
  // ********************************************************
  always_comb begin
    state_next = state_reg;
    if (wr.en) begin
      unique case (wr.field)
        `FIELD_DATA, `FIELD_RMW: state_next.latch = wr.data[WIDTH-1:0];
        `FIELD_DIR: state_next.dir = wr.data[WIDTH-1:0];
        `FIELD_DRIVE: state_next.drive = wr.data[WIDTH-1:0];
      endcase
    end
    // Open-drain bits only ever pull low; a latched one releases the pin
    state_next.out = state_reg.latch & ~state_reg.drive;
    state_next.oe = state_reg.dir & (~state_reg.drive | ~state_reg.latch);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pin_out = state_reg.out;
  assign pin_oe = state_reg.oe;
  assign pin_rd = pin_in;
  assign rmw_rd = (state_reg.drive & state_reg.latch) | (~state_reg.drive & pin_in);
  assign dir_rd = state_reg.dir;
  assign drive_rd = state_reg.drive;

endmodule : general_port

/* File: verilog/analog_shared_and_open_drain_ports.sv */
// Analog-shared port, four byte-wide and one nibble general port behind AXI4-Lite
// Contract
// - Reset clears the analog port direction and latch and sets analog-input-disable.
// - An analog port bit with direction 0 and latch 1 is a digital input that reads the pin.
// - With analog use disabled, a bit with direction 0 and latch 0 reads 0.
// - With analog use enabled, a bit with direction 0 and latch 0 is analog input and reads 0.
// - A bit with direction 1 drives its pin from its latch; bit 7 drives its latch ANDed with the debug output.
// - Four 8-bit and one 4-bit general port each have direction bits, 0 input, 1 output.
// - Reset clears every general port direction and latch, leaving all pins inputs.
// - Each general port has drive-type bits, reset to 0 for tri-state, 1 for open-drain.
// - The read-modify-write read returns latch for open-drain bits, other reads the pins.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "gpio_cfg.svh"

module analog_shared_and_open_drain_ports #(
  parameter int WIDE_WIDTH = 8,
  parameter int NIBBLE_WIDTH = 4,
  parameter int WIDE_PORTS = 4
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [15:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [15:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  input wire logic [7:0] ANALOG_PIN_IN,
  output logic [7:0] ANALOG_PIN_OUT,
  output logic [7:0] ANALOG_PIN_OE,
  input wire logic DEBUG_OUTPUT_TWO,
  output logic ANALOG_INPUT_DISABLE,
  output logic [3:0] ANALOG_CHANNEL_SELECT,
  input wire logic [WIDE_PORTS*WIDE_WIDTH+NIBBLE_WIDTH-1:0] GEN_PIN_IN,
  output logic [WIDE_PORTS*WIDE_WIDTH+NIBBLE_WIDTH-1:0] GEN_PIN_OUT,
  output logic [WIDE_PORTS*WIDE_WIDTH+NIBBLE_WIDTH-1:0] GEN_PIN_OE
);

  localparam int NUM_PORTS = WIDE_PORTS + 1;

  gpio_pkg::top_state_t state_reg;
  gpio_pkg::top_state_t state_next;

  gpio_pkg::port_wr_t port_wr[NUM_PORTS];
  logic [7:0] g_pin[NUM_PORTS];
  logic [7:0] g_rmw[NUM_PORTS];
  logic [7:0] g_dir[NUM_PORTS];
  logic [7:0] g_drive[NUM_PORTS];

  gpio_pkg::dec_t wr_dec;
  gpio_pkg::dec_t rd_dec;
  logic wr_commit;
  logic wr_fire;

  // ********************************************************
  // Address decode, shared by the read and write paths
  // ********************************************************
  function automatic gpio_pkg::dec_t decode(input logic [15:0] addr);
    logic [13:0] idx;
    logic [13:0] rel;
    decode.sel = gpio_pkg::SEL_NONE;
    decode.port = 3'h0;
    decode.field = 2'h0;
    idx = addr[15:2];
    rel = idx - `GEN_BASE_IDX;
    // Unaligned addresses decode to nothing and so answer with an error
    if (addr[1:0] == `LANE_ALIGN) begin
      if (idx == `AP_LATCH_IDX) begin
        decode.sel = gpio_pkg::SEL_AP_LATCH;
      end else if (idx == `AP_DIR_IDX) begin
        decode.sel = gpio_pkg::SEL_AP_DIR;
      end else if (idx == `CONV_CTRL_IDX) begin
        decode.sel = gpio_pkg::SEL_CONV;
      end else if (idx >= `GEN_BASE_IDX && rel < `GEN_SPAN) begin
        decode.sel = gpio_pkg::SEL_GEN;
        decode.port = rel[4:2];
        decode.field = rel[1:0];
      end
    end
  endfunction : decode

  // ********************************************************
  // Response code, shared by the read and write paths
  // ********************************************************
  function automatic logic [1:0] resp_code(input gpio_pkg::sel_t sel);
    resp_code = `RESP_OKAY;
    if (sel == gpio_pkg::SEL_NONE) begin
      resp_code = `RESP_SLVERR;
    end
  endfunction : resp_code

  // ********************************************************
  // Analog-shared port read view
  // ********************************************************
  // Input bits with a cleared latch read 0 whether the converter uses them
  // or not, so a read never leaks the level of a pin given to analog use
  function automatic logic [7:0] analog_view(input logic [7:0] dir, input logic [7:0] latch,
                                             input logic [7:0] pin);
    analog_view = (dir | latch) & pin;
  endfunction : analog_view

  // ********************************************************
  // General port read view by register field
  // ********************************************************
  function automatic logic [7:0] port_view(input logic [1:0] field, input logic [7:0] pin,
                                           input logic [7:0] dir, input logic [7:0] drive,
                                           input logic [7:0] rmw);
    port_view = pin;
    unique case (field)
      `FIELD_DATA: port_view = pin;
      `FIELD_DIR: port_view = dir;
      `FIELD_DRIVE: port_view = drive;
      `FIELD_RMW: port_view = rmw;
    endcase
  endfunction : port_view

  // ********************************************************
  // General ports
  // ********************************************************
  // Port k owns pin bits from 8k upward; the nibble port takes the top four
  genvar k;
  generate
    for (k = 0; k < NUM_PORTS; k++) begin : g_port
      localparam int W = (k < WIDE_PORTS) ? WIDE_WIDTH : NIBBLE_WIDTH;
      localparam int LO = k * WIDE_WIDTH;
      logic [W-1:0] pin_rd;
      logic [W-1:0] rmw_rd;
      logic [W-1:0] dir_rd;
      logic [W-1:0] drive_rd;

      always_comb begin
        port_wr[k].en = wr_fire && wr_dec.sel == gpio_pkg::SEL_GEN
                        && wr_dec.port == 3'(k);
        port_wr[k].field = wr_dec.field;
        // A narrow port keeps only the low bits of the written byte
        port_wr[k].data = state_reg.w_data[7:0];
      end

      general_port #(
        .WIDTH(W)
      ) u_port (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .wr(port_wr[k]),
        .pin_in(GEN_PIN_IN[LO+W-1:LO]),
        .pin_out(GEN_PIN_OUT[LO+W-1:LO]),
        .pin_oe(GEN_PIN_OE[LO+W-1:LO]),
        .pin_rd(pin_rd),
        .rmw_rd(rmw_rd),
        .dir_rd(dir_rd),
        .drive_rd(drive_rd)
      );

      // Narrow port reads zero in the upper bits
      assign g_pin[k] = 8'(pin_rd);
      assign g_rmw[k] = 8'(rmw_rd);
      assign g_dir[k] = 8'(dir_rd);
      assign g_drive[k] = 8'(drive_rd);
    end
  endgenerate

  // ********************************************************
  // Bus slave and analog-shared port
  // ********************************************************
  assign wr_dec = decode(state_reg.aw_addr);
  assign rd_dec = decode(S_AXI_ARADDR);
  // A write commits once both halves are held and the last response has gone
  assign wr_commit = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
  // Only the low byte lane carries register data
  assign wr_fire = wr_commit && state_reg.w_strb[0];

  always_comb begin
    state_next = state_reg;

    // ********************************************************
    // Write channels
    // ********************************************************
    // Write address and data are taken independently, in either order
    if (S_AXI_AWVALID && state_reg.awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && state_reg.wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = S_AXI_WDATA;
      state_next.w_strb = S_AXI_WSTRB;
    end
    if (state_reg.bvalid && S_AXI_BREADY) begin
      state_next.bvalid = 1'b0;
    end

    if (wr_commit) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = resp_code(wr_dec.sel);
      if (wr_fire) begin
        unique case (wr_dec.sel)
          gpio_pkg::SEL_AP_LATCH: state_next.ap_latch = state_reg.w_data[7:0];
          gpio_pkg::SEL_AP_DIR: state_next.ap_dir = state_reg.w_data[7:0];
          gpio_pkg::SEL_CONV: begin
            state_next.analog_input_disable = state_reg.w_data[`CONV_DISABLE_BIT];
            state_next.chan = state_reg.w_data[`CONV_CHAN_HI:`CONV_CHAN_LO];
          end
          gpio_pkg::SEL_GEN, gpio_pkg::SEL_NONE: begin
          end
        endcase
      end
    end

    // ********************************************************
    // Read channels
    // ********************************************************
    // One read is outstanding at a time
    if (state_reg.rvalid && S_AXI_RREADY) begin
      state_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = resp_code(rd_dec.sel);
      state_next.rdata = `WORD_ZERO;
      unique case (rd_dec.sel)
        gpio_pkg::SEL_AP_LATCH: state_next.rdata[7:0] =
            analog_view(state_reg.ap_dir, state_reg.ap_latch, ANALOG_PIN_IN);
        gpio_pkg::SEL_AP_DIR: state_next.rdata[7:0] = state_reg.ap_dir;
        gpio_pkg::SEL_CONV: begin
          state_next.rdata[`CONV_DISABLE_BIT] = state_reg.analog_input_disable;
          state_next.rdata[`CONV_CHAN_HI:`CONV_CHAN_LO] = state_reg.chan;
        end
        gpio_pkg::SEL_GEN: state_next.rdata[7:0] = port_view(rd_dec.field, g_pin[rd_dec.port],
            g_dir[rd_dec.port], g_drive[rd_dec.port], g_rmw[rd_dec.port]);
        gpio_pkg::SEL_NONE: state_next.rdata = `WORD_ZERO;
      endcase
    end

    // Readiness follows the next state, so a channel frees on the same edge
    // as its response leaves and back-to-back transfers lose no cycle
    state_next.awready = !state_next.aw_held && !state_next.bvalid;
    state_next.wready = !state_next.w_held && !state_next.bvalid;
    state_next.arready = !state_next.rvalid;

    // ********************************************************
    // Analog port pin drive
    // ********************************************************
    // Output enable follows the direction and the value the latch; bit 7 also carries the debug output,
    // which only shows while its latch bit holds 1
    state_next.ap_oe = state_reg.ap_dir;
    state_next.ap_out = state_reg.ap_latch;
    state_next.ap_out[`DEBUG_BIT] = state_reg.ap_latch[`DEBUG_BIT] & DEBUG_OUTPUT_TWO;
  end

  // Channels leave reset ready, so the first request is taken at once
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= '0;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
      state_reg.ap_latch <= `AP_RESET;
      state_reg.ap_dir <= `AP_RESET;
      state_reg.analog_input_disable <= `DISABLE_RESET;
      state_reg.chan <= `CHAN_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ********************************************************
  // Outputs, all straight from the state register
  // ********************************************************
  assign S_AXI_AWREADY = state_reg.awready;
  assign S_AXI_WREADY = state_reg.wready;
  assign S_AXI_BVALID = state_reg.bvalid;
  assign S_AXI_BRESP = state_reg.bresp;
  assign S_AXI_ARREADY = state_reg.arready;
  assign S_AXI_RVALID = state_reg.rvalid;
  assign S_AXI_RDATA = state_reg.rdata;
  assign S_AXI_RRESP = state_reg.rresp;
  assign ANALOG_PIN_OUT = state_reg.ap_out;
  assign ANALOG_PIN_OE = state_reg.ap_oe;
  assign ANALOG_INPUT_DISABLE = state_reg.analog_input_disable;
  assign ANALOG_CHANNEL_SELECT = state_reg.chan;

endmodule : analog_shared_and_open_drain_ports

/* File: verif/port_checker.sv */
// Bus timing and pin relation checks for the port block
`timescale 1ns/10ps
module port_checker #(
  parameter int WIDE_WIDTH = 8,
  parameter int NIBBLE_WIDTH = 4,
  parameter int WIDE_PORTS = 4
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [15:0] S_AXI_ARADDR,
  input wire logic S_AXI_RVALID,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [7:0] ANALOG_PIN_IN,
  input wire logic [7:0] ANALOG_PIN_OE,
  input wire logic ANALOG_INPUT_DISABLE,
  input wire logic [WIDE_PORTS*WIDE_WIDTH+NIBBLE_WIDTH-1:0] GEN_PIN_OE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  rst_state_a: assert property ($rose(RESET_N) |->
    ANALOG_INPUT_DISABLE && ANALOG_PIN_OE == '0 && GEN_PIN_OE == '0)
    else $error("pins or disable wrong after reset");
  wr_resp_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("write response late or early");
  rd_resp_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read response missing");
  ar_ready_a: assert property (S_AXI_ARREADY != S_AXI_RVALID)
    else $error("read ready not inverse of read valid");
  an_read_a: assert property ($rose(S_AXI_RVALID) && $past(S_AXI_ARADDR) == 16'h001c |->
    (S_AXI_RDATA[7:0] & ~$past(ANALOG_PIN_IN)) == 8'h00 && S_AXI_RDATA[31:8] == 24'h0 &&
    ((S_AXI_RDATA[7:0] ^ $past(ANALOG_PIN_IN)) & $past(ANALOG_PIN_OE)) == 8'h00)
    else $error("analog port read not masked pin value");
  oe_move_a: assert property ($changed(ANALOG_PIN_OE) || $changed(GEN_PIN_OE) |->
    $past(S_AXI_BVALID) && !$past(S_AXI_BVALID, 2)) else $error("pin enable moved without write");
  dis_move_a: assert property ($changed(ANALOG_INPUT_DISABLE) |-> $rose(S_AXI_BVALID) ||
    ($past(S_AXI_BVALID) && !$past(S_AXI_BVALID, 2))) else $error("disable moved without write");
endmodule : port_checker

bind analog_shared_and_open_drain_ports port_checker #(.WIDE_WIDTH(WIDE_WIDTH),
  .NIBBLE_WIDTH(NIBBLE_WIDTH), .WIDE_PORTS(WIDE_PORTS)) port_checker_inst (.*);

/* File: verif/board_model.sv */
// Board side of the port pins: external sources and pull-ups
`timescale 1ns/10ps
module board_model #(
  parameter int W = 36
) (
  input wire logic [W-1:0] gen_out,
  input wire logic [W-1:0] gen_oe,
  input wire logic [W-1:0] gen_src,
  input wire logic [W-1:0] gen_src_en,
  input wire logic [7:0] an_out,
  input wire logic [7:0] an_oe,
  input wire logic [7:0] an_src,
  output logic [W-1:0] gen_pin,
  output logic [7:0] an_pin
);
  // Released open-drain lines with no source enabled rise to the pull-up, never hold old data
  assign gen_pin = (gen_oe & gen_out) | (~gen_oe & gen_src_en & gen_src) | (~gen_oe & ~gen_src_en);
  // The source stands off where the port drives, so outputs never fight it
  assign an_pin = (an_oe & an_out) | (~an_oe & an_src);
endmodule : board_model

/* File: verif/tb.sv */
// Self-checking bench for the port block
`timescale 1ns/10ps
module tb;
  localparam int W = 36;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, dbg = 1;
  logic [15:0] awa = '0, ara = '0;
  logic [31:0] wd = '0;
  logic awr, wr, bv, arr, rv, dis;
  logic [1:0] br, rr;
  logic [31:0] rdt;
  logic [7:0] apo, apoe, apin, asrc = '0;
  logic [3:0] chan, ws = 4'hf;
  logic [W-1:0] go, goe, gpin, gsrc = '0, gen = '0;
  int n_errors = 0, check_count = 0, cyc = 0;
  integer seed = 32'hb9e9;
  analog_shared_and_open_drain_ports analog_shared_and_open_drain_ports_inst (
    .CORE_CLK(clk), .RESET_N(rst_n), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
    .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .S_AXI_RDATA(rdt),
    .S_AXI_RRESP(rr), .ANALOG_PIN_IN(apin), .ANALOG_PIN_OUT(apo), .ANALOG_PIN_OE(apoe),
    .DEBUG_OUTPUT_TWO(dbg), .ANALOG_INPUT_DISABLE(dis), .ANALOG_CHANNEL_SELECT(chan),
    .GEN_PIN_IN(gpin), .GEN_PIN_OUT(go), .GEN_PIN_OE(goe));
  board_model board_model_inst (.gen_out(go), .gen_oe(goe), .gen_src(gsrc),
    .gen_src_en(gen), .an_out(apo), .an_oe(apoe), .an_src(asrc), .gen_pin(gpin),
    .an_pin(apin));
  always #25 clk = ~clk;
  // *****
  // Hang guard
  // *****
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Handshakes are judged at the falling edge, where both sides are settled
  task automatic wr32(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, h;
    h = 0;
    @(posedge clk);
    awv <= 1;
    awa <= a;
    wv <= 1;
    wd <= d;
    bre <= 1;
    while (!h) begin
      @(negedge clk);
      ta = awr && awv;
      tw = wr && wv;
      h = bv;
      r = br;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (h) bre <= 0;
    end
  endtask : wr32
  task automatic rd32(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t, h;
    h = 0;
    @(posedge clk);
    arv <= 1;
    ara <= a;
    rre <= 1;
    while (!h) begin
      @(negedge clk);
      t = arr && arv;
      h = rv;
      d = rdt;
      r = rr;
      @(posedge clk);
      if (t) arv <= 0;
      if (h) rre <= 0;
    end
  endtask : rd32
  function automatic logic [7:0] drv(input logic [7:0] l, d, s);
    return (d & l) | (~d & s);
  endfunction : drv
  initial begin
    logic [31:0] v;
    logic [7:0] l, dr, od, s, m, p;
    logic [3:0] c;
    logic [1:0] r;
    logic [15:0] b;
    int k;
    bit en, dg;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    asrc <= 8'($random(seed));
    rd32(16'h7e40, v, r);
    chk("conv", 32'h80, v);
    rd32(16'h001c, v, r);
    chk("an_low", 32'h0, v);
    rd32(16'h7e34, v, r);
    chk("an_dir", 32'h0, v);
    for (int i = 0; i < 10; i++) begin
      rd32(16'h7e84 + 16'(16 * (i / 2) + 4 * (i % 2)), v, r);
      chk("gen_ctl", 32'h0, v);
    end
    chk("gen_oe", 32'h0, goe[31:0] | 32'(goe[W-1:32]));
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      en = i >= 4;
      l = 8'($random(seed));
      if (i % 2 == 1) l[7] = 1'b1;
      dr = en ? 8'h00 : 8'($random(seed));
      dg = 1'($random(seed));
      dbg <= dg;
      c = 4'($random(seed));
      asrc <= 8'($random(seed));
      wr32(16'h7e40, 32'h80, r);
      wr32(16'h001c, 32'(l), r);
      wr32(16'h7e34, 32'(dr), r);
      wr32(16'h7e40, 32'({!en, 3'h0, c}), r);
      chk("disable", 32'(!en), 32'(dis));
      chk("chan", 32'(c), 32'(chan));
      rd32(16'h001c, v, r);
      chk("an_read", 32'(drv(l & {dg, 7'h7f}, dr, asrc) & (dr | l)), v);
      chk("an_oe", 32'(dr), 32'(apoe));
      chk("an_out", 32'(l & {dg, 7'h7f} & dr), 32'(apo & dr));
    end
    $display("test analog done");
    for (int i = 0; i < 10; i++) begin
      k = i % 5;
      m = (k == 4) ? 8'h0f : 8'hff;
      b = 16'h7e80 + 16'(16 * k);
      l = 8'($random(seed)) & m;
      dr = 8'($random(seed)) & m;
      od = 8'($random(seed)) & m;
      gsrc <= W'({$random(seed), $random(seed)});
      gen <= ~(W'(dr) << (8 * k));
      wr32(b + ((i < 5) ? 16'h0 : 16'hc), 32'(l), r);
      wr32(b + 16'h4, 32'(dr), r);
      wr32(b + 16'h8, 32'(od), r);
      s = 8'(gsrc >> (8 * k)) & m;
      p = drv(l, dr, s);
      rd32(b, v, r);
      chk("gen_pin", 32'(p), v);
      rd32(b + 16'hc, v, r);
      chk("gen_rmw", 32'((od & l) | (~od & p)), v);
      rd32(b + 16'h8, v, r);
      chk("gen_drive", 32'(od), v);
      chk("gen_oe", 32'(dr & ~(od & l)), 32'(8'(goe >> (8 * k)) & m));
      chk("gen_out", 32'(l & dr & ~od), 32'(8'(go >> (8 * k)) & dr));
    end
    $display("test general done");
    wr32(16'h7000, 32'h1, r);
    chk("bad_wr", 32'h2, 32'(r));
    wr32(16'h001d, 32'h1, r);
    chk("odd_wr", 32'h2, 32'(r));
    rd32(16'h7000, v, r);
    chk("bad_rd", 32'h2, 32'(r));
    chk("bad_data", 32'h0, v);
    ws <= 4'he;
    wr32(16'h7e34, 32'hff, r);
    chk("strb_resp", 32'h0, 32'(r));
    ws <= 4'hf;
    rd32(16'h7e34, v, r);
    chk("strb_off", 32'h0, v);
    $display("test unmapped done");
    summarize();
  end
endmodule : tb
